/* sso_standby.sv */
// Functional notes
// - halt instruction stops the cpu clock
// - running oscillators keep oscillating during halt
// - stop halts high-speed and internal high-speed oscillators
// - interrupt request releases halt and stop
// - registers, memory and ports held in standby
// - crystal cpu clock waits selected time after stop
// - status cleared on reset, stop, oscillator stop
// - status bits set in order, then stay
// - status bits mark 2^11..2^16 crystal cycles
// - counter stops at selected time
// - select codes 001..101, others prohibited
// - reset selects longest wait 2^16
// - count only while oscillation is present
// - status read-only; select written by bytes only
module sso_standby
  import sso_pkg::*;
(
  input  wire logic         core_clk_in,         // core clock, 20 MHz
  input  wire logic         srst_in,             // synchronous reset, high
  input  wire logic         ce_in,               // clock enable, freezes state
  input  wire sso_bus_req_t bus_req_in,          // cpu register access
  input  wire logic         halt_exec_in,        // halt instruction pulse
  input  wire logic         stop_exec_in,        // stop instruction pulse
  input  wire logic         irq_req_in,          // pending interrupt request
  input  wire logic         cpu_on_crystal_in,   // cpu runs from crystal
  input  wire logic         main_osc_stop_bit_in, // oscillator stop bit level
  input  wire logic         hs_osc_req_in,       // high-speed osc wanted
  input  wire logic         ih_osc_req_in,       // internal high-speed wanted
  input  wire logic         il_osc_req_in,       // internal low-speed wanted
  input  wire logic         crystal_clock_in,    // crystal clock pin
  input  wire logic         osc_present_in,      // crystal oscillation seen
  output logic [7:0]        rdata_out,           // register read data
  output logic              cpu_clk_en_out,      // cpu clock gate enable
  output logic              hs_osc_en_out,       // high-speed osc enable
  output logic              ih_osc_en_out,       // internal high-speed enable
  output logic              il_osc_en_out,       // internal low-speed enable
  output logic              hold_out,            // retain all state
  output logic              wake_out             // pulse, cpu resumes
);

  sso_state_t                state_reg;
  sso_state_t                state_next;
  logic [SSO_SEL_W-1:0]      sel_reg;
  logic [SSO_FLAG_W-1:0]     status_reg;
  logic [SSO_CNT_W-1:0]      cnt_reg;
  logic                      count_en_reg;
  logic                      osc_stop_d_reg;
  logic [2:0]                xtal_sync_reg;
  logic [1:0]                osc_sync_reg;
  logic                      xtal_edge;
  logic                      osc_ok;
  logic                      cnt_done;
  logic                      stab_clear;
  logic                      sel_wr;

  // terminal count of a select code; prohibited codes take the longest wait
  function automatic logic [SSO_CNT_W-1:0] term_of(input logic [SSO_SEL_W-1:0] s);
    unique case (s)
      SSO_SEL_2P11: term_of = SSO_CNT_2P11;
      SSO_SEL_2P13: term_of = SSO_CNT_2P13;
      SSO_SEL_2P14: term_of = SSO_CNT_2P14;
      SSO_SEL_2P15: term_of = SSO_CNT_2P15;
      default:      term_of = SSO_CNT_2P16;
    endcase
  endfunction

  // thresholds reached by a count, shortest in the top bit
  function automatic logic [SSO_FLAG_W-1:0] flags_of(input logic [SSO_CNT_W-1:0] c);
    flags_of = '0;
    flags_of[SSO_BIT_2P11] = (c >= SSO_CNT_2P11);
    flags_of[SSO_BIT_2P13] = (c >= SSO_CNT_2P13);
    flags_of[SSO_BIT_2P14] = (c >= SSO_CNT_2P14);
    flags_of[SSO_BIT_2P15] = (c >= SSO_CNT_2P15);
    flags_of[SSO_BIT_2P16] = (c >= SSO_CNT_2P16);
  endfunction

  // crystal and oscillation detect are foreign, two flops before use;
  // the crystal must run below half the core clock to be seen
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      xtal_sync_reg <= 3'h0;
      osc_sync_reg  <= 2'h0;
    end else if (ce_in) begin
      xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_clock_in};
      osc_sync_reg  <= {osc_sync_reg[0], osc_present_in};
    end
  end

  assign xtal_edge  = xtal_sync_reg[1] & ~xtal_sync_reg[2];
  assign osc_ok     = osc_sync_reg[1];
  assign cnt_done   = (cnt_reg >= term_of(sel_reg));
  // the count clears on stop or on the oscillator stop bit
  assign stab_clear = (stop_exec_in && state_reg == SSO_ST_RUN)
                    || main_osc_stop_bit_in;
  assign sel_wr     = bus_req_in.wr && !bus_req_in.bit_acc
                    && bus_req_in.addr == SSO_SELECT_ADDR;

  // standby sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SSO_ST_RUN: begin
        if (stop_exec_in)
          state_next = SSO_ST_STOP;
        else if (halt_exec_in)
          state_next = SSO_ST_HALT;
      end
      SSO_ST_HALT: begin
        if (irq_req_in)
          state_next = SSO_ST_RUN;
      end
      SSO_ST_STOP: begin
        if (irq_req_in)
          state_next = cpu_on_crystal_in ? SSO_ST_WAIT : SSO_ST_RUN;
      end
      SSO_ST_WAIT: begin
        if (cnt_done)
          state_next = SSO_ST_RUN;
      end
      default: state_next = SSO_ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      state_reg <= SSO_ST_RUN;
    else if (ce_in)
      state_reg <= state_next;
  end

  // resume pulse when the cpu clock comes back
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      wake_out <= 1'b0;
    else if (ce_in)
      wake_out <= (state_reg != SSO_ST_RUN) && (state_next == SSO_ST_RUN);
  end

  // clock gating and high-speed oscillator enables follow the state; internal low-speed follows its request only
  assign cpu_clk_en_out = (state_reg == SSO_ST_RUN);
  assign hs_osc_en_out  = hs_osc_req_in && state_reg != SSO_ST_STOP;
  assign ih_osc_en_out  = ih_osc_req_in && state_reg != SSO_ST_STOP;
  assign il_osc_en_out  = il_osc_req_in;
  // the rest of the chip freezes its registers, ram and port latches
  assign hold_out       = (state_reg != SSO_ST_RUN);

  // select register; bit writes are ignored, only byte stores land
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      sel_reg <= SSO_SELECT_RST[SSO_SEL_W-1:0];
    else if (ce_in && sel_wr)
      sel_reg <= bus_req_in.wdata[SSO_SEL_W-1:0];
  end

  // counting starts after stop release or when the oscillator is let run
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      count_en_reg   <= 1'b1;
      osc_stop_d_reg <= 1'b0;
    end else if (ce_in) begin
      osc_stop_d_reg <= main_osc_stop_bit_in;
      if (stab_clear)
        count_en_reg <= 1'b0;
      else if ((state_reg == SSO_ST_STOP && irq_req_in) || osc_stop_d_reg)
        count_en_reg <= 1'b1;
    end
  end

  // stabilization counter on sampled crystal edges, saturating
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      cnt_reg <= '0;
    else if (ce_in) begin
      if (stab_clear)
        cnt_reg <= '0;
      else if (count_en_reg && osc_ok && xtal_edge && !cnt_done)
        cnt_reg <= cnt_reg + 17'h00001;
    end
  end

  // sticky status; a clear restarts the count so nothing is lost
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      status_reg <= SSO_STATUS_RST[SSO_FLAG_W-1:0];
    else if (ce_in) begin
      if (stab_clear)
        status_reg <= '0;
      else
        status_reg <= status_reg | flags_of(cnt_reg);
    end
  end

  // byte or bit reads; unmapped addresses and upper bits read zero
  always_ff @(posedge core_clk_in) begin
    if (srst_in)
      rdata_out <= 8'h00;
    else if (ce_in && bus_req_in.rd) begin
      if (bus_req_in.addr == SSO_STATUS_ADDR)
        rdata_out <= {3'h0, status_reg};
      else if (bus_req_in.addr == SSO_SELECT_ADDR)
        rdata_out <= {5'h00, sel_reg};
      else
        rdata_out <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_halt_clk;
    state_reg == SSO_ST_HALT |-> !cpu_clk_en_out && hold_out;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("cpu clock runs in halt");

  property p_halt_osc;
    state_reg == SSO_ST_HALT |-> hs_osc_en_out == hs_osc_req_in
      && ih_osc_en_out == ih_osc_req_in;
  endproperty
  a_halt_osc: assert property (p_halt_osc) else $error("oscillator lost in halt");

  property p_stop_osc;
    ce_in && state_reg == SSO_ST_RUN && stop_exec_in
      |=> !hs_osc_en_out && !ih_osc_en_out && !cpu_clk_en_out;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("stop left oscillators on");

  property p_halt_wake;
    ce_in && state_reg == SSO_ST_HALT && irq_req_in |=> cpu_clk_en_out && wake_out;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("halt not released");

  property p_stop_wake;
    ce_in && state_reg == SSO_ST_STOP && irq_req_in
      |=> state_reg == ($past(cpu_on_crystal_in) ? SSO_ST_WAIT : SSO_ST_RUN);
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop not released");

  property p_hold;
    !cpu_clk_en_out |-> hold_out;
  endproperty
  a_hold: assert property (p_hold) else $error("state not held in standby");

  property p_wait_done;
    ce_in && state_reg == SSO_ST_WAIT && cnt_reg >= term_of(sel_reg) |=> cpu_clk_en_out;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("wait did not end");

  property p_wait_early;
    state_reg == SSO_ST_WAIT |-> cnt_reg <= term_of(sel_reg) && !cpu_clk_en_out;
  endproperty
  a_wait_early: assert property (p_wait_early) else $error("cpu resumed early");

  property p_stop_clear;
    ce_in && state_reg == SSO_ST_RUN && stop_exec_in |=> status_reg == '0 && cnt_reg == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("status not cleared");

  property p_sticky;
    ce_in && !stab_clear |=> (status_reg & $past(status_reg)) == $past(status_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");

  property p_thermo;
    status_reg inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f};
  endproperty
  a_thermo: assert property (p_thermo) else $error("status out of order");

  property p_sat;
    cnt_reg <= term_of(sel_reg) || $past(sel_wr);
  endproperty
  a_sat: assert property (p_sat) else $error("counter ran past select");

  property p_sel_rst;
    srst_in |=> sel_reg == SSO_SEL_2P16;
  endproperty
  a_sel_rst: assert property (disable iff (1'b0) p_sel_rst) else $error("bad select reset");

  property p_bitwr;
    ce_in && bus_req_in.wr && bus_req_in.bit_acc |=> $stable(sel_reg);
  endproperty
  a_bitwr: assert property (p_bitwr) else $error("bit write changed select");

  property p_osc_gate;
    ce_in && !osc_ok && !stab_clear |=> $stable(cnt_reg);
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("counted without oscillation");

  c_halt_cycle: cover property (state_reg == SSO_ST_HALT ##1 state_reg == SSO_ST_RUN);
  c_stop_wait:  cover property (state_reg == SSO_ST_WAIT ##1 state_reg == SSO_ST_RUN);
  c_stop_fast:  cover property (state_reg == SSO_ST_STOP ##1 state_reg == SSO_ST_RUN);
  c_full:       cover property (status_reg == 5'h1f);

endmodule

/* sso_pkg.sv */
package sso_pkg;

  // register map of the standby controller
  localparam logic [15:0] SSO_STATUS_ADDR = 16'hffa3;
  localparam logic [15:0] SSO_SELECT_ADDR = 16'hffa4;
  localparam logic [7:0]  SSO_STATUS_RST  = 8'h00;
  localparam logic [7:0]  SSO_SELECT_RST  = 8'h05;

  // select, status flag and counter widths
  localparam int          SSO_SEL_W       = 3;
  localparam int          SSO_FLAG_W      = 5;
  localparam int          SSO_CNT_W       = 17;

  // legal select codes
  localparam logic [2:0]  SSO_SEL_2P11    = 3'h1;
  localparam logic [2:0]  SSO_SEL_2P13    = 3'h2;
  localparam logic [2:0]  SSO_SEL_2P14    = 3'h3;
  localparam logic [2:0]  SSO_SEL_2P15    = 3'h4;
  localparam logic [2:0]  SSO_SEL_2P16    = 3'h5;

  // stabilization thresholds in crystal cycles
  localparam logic [16:0] SSO_CNT_2P11    = 17'h00800;
  localparam logic [16:0] SSO_CNT_2P13    = 17'h02000;
  localparam logic [16:0] SSO_CNT_2P14    = 17'h04000;
  localparam logic [16:0] SSO_CNT_2P15    = 17'h08000;
  localparam logic [16:0] SSO_CNT_2P16    = 17'h10000;

  // status flag positions
  localparam int          SSO_BIT_2P11    = 4;
  localparam int          SSO_BIT_2P13    = 3;
  localparam int          SSO_BIT_2P14    = 2;
  localparam int          SSO_BIT_2P15    = 1;
  localparam int          SSO_BIT_2P16    = 0;

  // standby states, one-hot
  typedef enum logic [3:0] {
    SSO_ST_RUN  = 4'h1,
    SSO_ST_HALT = 4'h2,
    SSO_ST_STOP = 4'h4,
    SSO_ST_WAIT = 4'h8
  } sso_state_t;

  // cpu register access
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_acc;
    logic [7:0]  wdata;
  } sso_bus_req_t;

endpackage

/* sso_xtal_model.sv */
// crystal oscillator on the far side of the standby controller
module sso_xtal_model #(
  parameter int HALF_NS  = 100,  // half period, 200 ns crystal period
  parameter int START_NS = 2000, // start-up time before oscillation shows
  parameter int SKEW_NS  = 10    // keeps crystal edges off core clock edges
) (
  input  wire logic en_in,       // oscillator enable from the device
  output logic      xtal_out,    // crystal clock pin
  output logic      present_out  // oscillation present
);
  timeunit 1ns;
  timeprecision 1ns;

  // the clock stands still low while disabled; start-up must not be counted
  initial begin
    xtal_out = 1'b0;
    present_out = 1'b0;
    forever begin
      wait (en_in === 1'b1);
      #(START_NS + SKEW_NS) present_out = 1'b1;
      while (en_in === 1'b1) begin
        #HALF_NS xtal_out = ~xtal_out;
      end
      xtal_out = 1'b0;
      present_out = 1'b0;
    end
  end
endmodule

/* tb_standby_osc_stabilization.sv */
module tb_standby_osc_stabilization import sso_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        w;
    logic        r;
    logic        b;
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } sso_row_t;

  localparam int LIMIT = 90000;      // about 75k cycles needed
  localparam int MIN_WAIT = 40 + 2047 * 4; // start-up plus 2047 crystal periods, in core cycles

  logic         core_clk_in;
  logic         srst_in;
  logic         halt_exec;
  logic         stop_exec;
  logic         irq_req;
  logic         cpu_on_xtal;
  logic         osc_stop_bit;
  logic         ce;
  logic [2:0]   osc_req;
  sso_bus_req_t req;
  logic         xtal;
  logic         present;
  logic [7:0]   rdata;
  logic         cpu_clk_en;
  logic         hs_en;
  logic         ih_en;
  logic         il_en;
  logic         hold;
  logic         wake;
  logic         saw11;
  int           n_mismatch = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           n;

  // plain register accesses: write, read, bit access, address, data, expected
  sso_row_t rows [0:10] = '{
    '{1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00, 8'h00},
    '{1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00, 8'h05},
    '{1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'h01, 8'h00},
    '{1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00, 8'h01},
    '{1'b1, 1'b0, 1'b0, SSO_STATUS_ADDR, 8'hff, 8'h00},
    '{1'b0, 1'b1, 1'b1, SSO_STATUS_ADDR, 8'h00, 8'h00},
    '{1'b1, 1'b0, 1'b1, SSO_SELECT_ADDR, 8'h03, 8'h00},
    '{1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00, 8'h01},
    '{1'b0, 1'b1, 1'b0, 16'hffa5,        8'h00, 8'h00},
    '{1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'hfd, 8'h00},
    '{1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00, 8'h05}
  };

  sso_standby u_dut (
    .core_clk_in          (core_clk_in),
    .srst_in              (srst_in),
    .ce_in                (ce),
    .bus_req_in           (req),
    .halt_exec_in         (halt_exec),
    .stop_exec_in         (stop_exec),
    .irq_req_in           (irq_req),
    .cpu_on_crystal_in    (cpu_on_xtal),
    .main_osc_stop_bit_in (osc_stop_bit),
    .hs_osc_req_in        (osc_req[2]),
    .ih_osc_req_in        (osc_req[1]),
    .il_osc_req_in        (osc_req[0]),
    .crystal_clock_in     (xtal),
    .osc_present_in       (present),
    .rdata_out            (rdata),
    .cpu_clk_en_out       (cpu_clk_en),
    .hs_osc_en_out        (hs_en),
    .ih_osc_en_out        (ih_en),
    .il_osc_en_out        (il_en),
    .hold_out             (hold),
    .wake_out             (wake)
  );

  sso_xtal_model u_xtal (
    .en_in       (hs_en),
    .xtal_out    (xtal),
    .present_out (present)
  );

  // 20 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; read data is settled right after the taking edge
  task automatic acc(input logic w, r, b, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wr: w, rd: r, bit_acc: b, wdata: d};
    @(posedge core_clk_in);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
  endtask

  // one-cycle instruction pulse: 0 halt, 1 stop, 2 interrupt
  task automatic instr(input int k);
    @(posedge core_clk_in);
    halt_exec <= (k == 0);
    stop_exec <= (k == 1);
    irq_req <= (k == 2);
    @(posedge core_clk_in);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
    irq_req <= 1'b0;
    #1;
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial begin
    srst_in = 1'b1;
    req = '0;
    halt_exec = 1'b0;
    stop_exec = 1'b0;
    irq_req = 1'b0;
    cpu_on_xtal = 1'b1;
    osc_stop_bit = 1'b0;
    ce = 1'b1;
    osc_req = 3'h7;
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].r, rows[i].b, rows[i].a, rows[i].d);
      if (rows[i].r) chk(rdata, rows[i].e);
    end
    for (int c = 1; c <= 5; c++) begin
      acc(1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'(c));
      acc(1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00);
      chk(rdata, 8'(c));
    end
    // select programmed before stop; no main-clock peripherals or converter here
    acc(1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'h01);
    // halt entry and interrupt release
    instr(0);
    chk({7'h0, cpu_clk_en}, 8'h00);
    chk({4'h0, hold, hs_en, ih_en, il_en}, 8'h0f);
    // an oscillator that is not wanted stays off in halt
    @(posedge core_clk_in);
    osc_req <= 3'h4;
    #1;
    chk({4'h0, hold, hs_en, ih_en, il_en}, 8'h0c);
    @(posedge core_clk_in);
    osc_req <= 3'h7;
    instr(2);
    chk({6'h0, cpu_clk_en, wake}, 8'h03);
    // stop on the crystal clock: release waits the selected time
    instr(1);
    chk({5'h0, cpu_clk_en, hs_en, ih_en}, 8'h00);
    acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
    chk(rdata, 8'h00);
    instr(2);
    n = 0;
    while (wake !== 1'b1 && n < 40000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    chk({7'h0, wake}, 8'h01);
    chk({7'h0, n >= MIN_WAIT}, 8'h01);
    acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
    chk(rdata, 8'h10);
    // stop on the internal clock: software polls the status instead
    acc(1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'h02);
    @(posedge core_clk_in);
    cpu_on_xtal <= 1'b0;
    instr(1);
    instr(2);
    chk({6'h0, cpu_clk_en, wake}, 8'h03);
    saw11 = 1'b0;
    n = 0;
    // select untouched while counting; polled time within the selected one
    do begin
      acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
      if (rdata === 8'h10) saw11 = 1'b1;
      n++;
    end while (rdata[3] !== 1'b1 && n < 20000);
    chk({7'h0, saw11}, 8'h01);
    chk(rdata, 8'h18);
    // long enough for the next threshold; the count must have stopped
    repeat (16500) acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
    chk(rdata, 8'h18);
    @(posedge core_clk_in);
    osc_stop_bit <= 1'b1;
    acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
    chk(rdata, 8'h00);
    @(posedge core_clk_in);
    osc_stop_bit <= 1'b0;
    acc(1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'h03);
    acc(1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00);
    chk(rdata, 8'h03);
    // clock enable low: a write and a halt are both lost
    @(posedge core_clk_in);
    ce <= 1'b0;
    acc(1'b1, 1'b0, 1'b0, SSO_SELECT_ADDR, 8'h04);
    instr(0);
    chk({6'h0, cpu_clk_en, hold}, 8'h02);
    @(posedge core_clk_in);
    ce <= 1'b1;
    acc(1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00);
    chk(rdata, 8'h03);
    // reset in mid-run, clock enable low, still restores both registers
    @(posedge core_clk_in);
    ce <= 1'b0;
    srst_in <= 1'b1;
    @(posedge core_clk_in);
    srst_in <= 1'b0;
    ce <= 1'b1;
    acc(1'b0, 1'b1, 1'b0, SSO_SELECT_ADDR, 8'h00);
    chk(rdata, 8'h05);
    acc(1'b0, 1'b1, 1'b0, SSO_STATUS_ADDR, 8'h00);
    chk(rdata, 8'h00);
    end_of_test;
  end
endmodule
